// ### hw/lbcu_top.v
// Overview of operation
// (RULE_01) AND, EOR, OR take 6-bit short, 24-bit long or register operand
// (RULE_02) bit 55 clear: field 47-24 gets 9 minus leading zeros
// (RULE_03) bit 55 set: field 47-24 gets 9 minus leading ones
// (RULE_04) extract width from control 17-12, offset from control 5-0
// (RULE_05) extraction has signed and unsigned variants
// (RULE_06) 16-bit mode: offset from control 13-8, width from 21-16
// (RULE_07) insert low bits of second source at control offset
// (RULE_08) logical shifts take single-bit or 5-bit immediate amount
// (RULE_09) logical shifts take amount from a control register operand
// (RULE_10) relative loop ends at PC plus 24-bit displacement, given count
// (RULE_11) endless relative loop has no count
// (RULE_12) conditional exit leaves any active loop, endless ones too
// (RULE_13) single-flag conditions on carry, zero, extension, limit, sign
// (RULE_14) signed compares from N eor V and Z
// (RULE_15) normalized when Z or (U and E) is one, else denormal
// (RULE_16) address load writes PC plus displacement
// (RULE_17) conditions are combinational from the current flags
// (RULE_18) early exit restores enclosing loop like normal completion
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lbcu_defines.vh"
module lbcu_top (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  output reg         LOOP_ACTIVE,
  output reg         PC_LOAD,
  output reg  [23:0] PC_TARGET
);

  function cond_eval;
    input [3:0] cc;
    input [6:0] f;
    reg nv;
    begin
      nv = f[`LBCU_F_N] ^ f[`LBCU_F_V];
      case (cc)
        4'h0: cond_eval = ~f[`LBCU_F_C]; // RULE_13
        4'h1: cond_eval = f[`LBCU_F_C];
        4'h2: cond_eval = ~f[`LBCU_F_E];
        4'h3: cond_eval = f[`LBCU_F_Z];
        4'h4: cond_eval = f[`LBCU_F_E];
        4'h5: cond_eval = ~nv; // RULE_14
        4'h6: cond_eval = ~(f[`LBCU_F_Z] | nv);
        4'h7: cond_eval = ~f[`LBCU_F_L];
        4'h8: cond_eval = f[`LBCU_F_Z] | nv;
        4'h9: cond_eval = f[`LBCU_F_L];
        4'hA: cond_eval = nv;
        4'hB: cond_eval = f[`LBCU_F_N];
        4'hC: cond_eval = ~f[`LBCU_F_Z];
        4'hD: cond_eval = f[`LBCU_F_Z] |
                          (f[`LBCU_F_U] & f[`LBCU_F_E]); // RULE_15
        4'hE: cond_eval = ~f[`LBCU_F_N];
        default: cond_eval = ~(f[`LBCU_F_Z] |
                          (f[`LBCU_F_U] & f[`LBCU_F_E]));
      endcase
    end
  endfunction

  reg        rd_pend_q;
  reg        wr_pend_q;
  reg [7:0]  addr_q;
  reg [55:0] acc_q;
  reg [23:0] opnd_q;
  reg [23:0] ctrl_q;
  reg [23:0] pc_q;
  reg [6:0]  flags_q;
  reg [10:0] cmd_q;
  reg [55:0] res_q;
  reg        lp_fe_q;
  reg [23:0] lp_end_q;
  reg [23:0] lp_cnt_q;
  reg        sv_act_q;
  reg        sv_fe_q;
  reg [23:0] sv_end_q;
  reg [23:0] sv_cnt_q;
  reg        brk_q;

  wire        take    = HSEL & HTRANS[1] & HREADY;
  wire        exe     = wr_pend_q & (addr_q == `LBCU_A_CMD);
  wire [3:0]  op      = HWDATA[`LBCU_CMD_OP];
  wire [1:0]  src     = HWDATA[`LBCU_CMD_SRC];
  wire        m16     = HWDATA[`LBCU_CMD_M16];
  wire        cc_now  = cond_eval(HWDATA[`LBCU_CMD_CC], flags_q);
  wire        cc_stat = cond_eval(cmd_q[`LBCU_CMD_CC], flags_q); // RULE_17
  wire [23:0] pc_sum  = pc_q + opnd_q;
  wire [23:0] lp_next = lp_end_q + 24'h000001;

  reg [23:0] lop;
  reg [23:0] lres;
  reg [5:0]  nlead;
  reg        run;
  reg [5:0]  wid;
  reg [5:0]  off;
  reg [4:0]  amt;
  reg [55:0] mask;
  reg [55:0] shv;
  reg [55:0] fld;
  reg        sx;
  reg [55:0] ins_m;
  reg [55:0] alu;
  integer    i;

  always @* begin
    lop   = opnd_q;
    lres  = `LBCU_RST24;
    nlead = 6'h00;
    run   = 1'b1;
    if (src == `LBCU_SRC_SHORT)
      lop = {18'h00000, opnd_q[5:0]}; // RULE_01
    for (i = 55; i >= 0; i = i - 1) begin
      if (run && (acc_q[i] == acc_q[55]))
        nlead = nlead + 6'h01; // RULE_02 RULE_03
      else
        run = 1'b0;
    end
    if (m16) begin
      wid = ctrl_q[`LBCU_WID16]; // RULE_06
      off = ctrl_q[`LBCU_OFF16];
    end else begin
      wid = ctrl_q[`LBCU_WID]; // RULE_04
      off = ctrl_q[`LBCU_OFF];
    end
    // a width of 56 or more leaves the mask all ones
    mask = ~({56{1'b1}} << wid);
    shv  = acc_q >> off;
    fld  = shv & mask;
    sx   = 1'b0;
    if ((wid != 6'h00) && (wid < 6'd56))
      sx = fld[wid - 6'h01];
    ins_m = mask << off;
    amt = 5'h01; // RULE_08
    if (src == `LBCU_SRC_SHORT)
      amt = opnd_q[4:0];
    else if (src == `LBCU_SRC_LONG)
      amt = ctrl_q[4:0]; // RULE_09
    alu = acc_q;
    case (op)
      `LBCU_OP_AND: lres = acc_q[47:24] & lop;
      `LBCU_OP_EOR: lres = acc_q[47:24] ^ lop;
      `LBCU_OP_OR:  lres = acc_q[47:24] | lop;
      `LBCU_OP_COUNT_LEADING_BITS:
        lres = `LBCU_LEAD_BASE - {18'h00000, nlead};
      `LBCU_OP_LOGICAL_LEFT_SHIFT:
        lres = acc_q[47:24] << amt; // RULE_08
      `LBCU_OP_LOGICAL_RIGHT_SHIFT:
        lres = acc_q[47:24] >> amt;
      default:      lres = acc_q[47:24];
    endcase
    case (op)
      `LBCU_OP_EXT:
        alu = fld | (sx ? ~mask : `LBCU_RST56); // RULE_05
      `LBCU_OP_EXTU:
        alu = fld; // RULE_05
      `LBCU_OP_INS:
        alu = (acc_q & ~ins_m) |
              (({32'h00000000, opnd_q} & mask) << off); // RULE_07
      `LBCU_OP_PC_RELATIVE_ADDRESS_LOAD:
        alu = {32'h00000000, pc_sum}; // RULE_16
      default:
        alu = {acc_q[55:48], lres, acc_q[23:0]};
    endcase
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      rd_pend_q <= take & ~HWRITE;
      wr_pend_q <= take & HWRITE;
      if (take)
        addr_q <= HADDR[7:0];
      // reads wait one cycle so a write just before is visible
      HREADYOUT <= ~(take & ~HWRITE);
      HRESP     <= 1'b0;
      if (rd_pend_q) begin
        case (addr_q)
          `LBCU_A_ACC_LO: HRDATA <= acc_q[31:0];
          `LBCU_A_ACC_HI: HRDATA <= {8'h00, acc_q[55:32]};
          `LBCU_A_OPND:   HRDATA <= {8'h00, opnd_q};
          `LBCU_A_CTRL:   HRDATA <= {8'h00, ctrl_q};
          `LBCU_A_PC:     HRDATA <= {8'h00, pc_q};
          `LBCU_A_FLAGS:  HRDATA <= {25'h0000000, flags_q};
          `LBCU_A_CMD:    HRDATA <= {21'h000000, cmd_q};
          `LBCU_A_RES_LO: HRDATA <= res_q[31:0];
          `LBCU_A_RES_HI: HRDATA <= {8'h00, res_q[55:32]};
          `LBCU_A_LSTAT:
            HRDATA <= {27'h0000000, brk_q, cc_stat, sv_act_q,
                       lp_fe_q, LOOP_ACTIVE};
          `LBCU_A_LEND:   HRDATA <= {8'h00, lp_end_q};
          `LBCU_A_LCNT:   HRDATA <= {8'h00, lp_cnt_q};
          default:        HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      acc_q   <= `LBCU_RST56;
      opnd_q  <= `LBCU_RST24;
      ctrl_q  <= `LBCU_RST24;
      pc_q    <= `LBCU_RST24;
      flags_q <= 7'h00;
      cmd_q   <= 11'h000;
      res_q   <= `LBCU_RST56;
    end else if (wr_pend_q) begin
      case (addr_q)
        `LBCU_A_ACC_LO: acc_q[31:0]  <= HWDATA;
        `LBCU_A_ACC_HI: acc_q[55:32] <= HWDATA[23:0];
        `LBCU_A_OPND:   opnd_q  <= HWDATA[23:0];
        `LBCU_A_CTRL:   ctrl_q  <= HWDATA[23:0];
        `LBCU_A_PC:     pc_q    <= HWDATA[23:0];
        `LBCU_A_FLAGS:  flags_q <= HWDATA[6:0];
        `LBCU_A_CMD: begin
          cmd_q <= HWDATA[10:0];
          if ((op <= `LBCU_OP_LOGICAL_RIGHT_SHIFT) ||
              (op == `LBCU_OP_PC_RELATIVE_ADDRESS_LOAD))
            res_q <= alu;
        end
        default: cmd_q <= cmd_q;
      endcase
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      LOOP_ACTIVE <= 1'b0;
      lp_fe_q     <= 1'b0;
      lp_end_q    <= `LBCU_RST24;
      lp_cnt_q    <= `LBCU_RST24;
      sv_act_q    <= 1'b0;
      sv_fe_q     <= 1'b0;
      sv_end_q    <= `LBCU_RST24;
      sv_cnt_q    <= `LBCU_RST24;
      brk_q       <= 1'b0;
      PC_LOAD     <= 1'b0;
      PC_TARGET   <= `LBCU_RST24;
    end else begin
      PC_LOAD <= 1'b0;
      if (exe) begin
        case (op)
          `LBCU_OP_PC_RELATIVE_LOOP_START,
          `LBCU_OP_ENDLESS_RELATIVE_LOOP: begin
            // one level of nesting is kept for the enclosing loop
            sv_act_q    <= LOOP_ACTIVE;
            sv_fe_q     <= lp_fe_q;
            sv_end_q    <= lp_end_q;
            sv_cnt_q    <= lp_cnt_q;
            LOOP_ACTIVE <= 1'b1;
            lp_end_q    <= pc_sum; // RULE_10
            brk_q       <= 1'b0;
            if (op == `LBCU_OP_ENDLESS_RELATIVE_LOOP) begin
              lp_fe_q  <= 1'b1; // RULE_11
              lp_cnt_q <= `LBCU_RST24;
            end else begin
              lp_fe_q  <= 1'b0;
              lp_cnt_q <= ctrl_q; // RULE_10
            end
          end
          `LBCU_OP_BRK, `LBCU_OP_STEP: begin
            if (LOOP_ACTIVE &&
                (((op == `LBCU_OP_BRK) && cc_now) || // RULE_12
                 ((op == `LBCU_OP_STEP) && !lp_fe_q &&
                  (lp_cnt_q <= 24'h000001)))) begin
              LOOP_ACTIVE <= sv_act_q; // RULE_18
              lp_fe_q     <= sv_fe_q;
              lp_end_q    <= sv_end_q;
              lp_cnt_q    <= sv_cnt_q;
              sv_act_q    <= 1'b0;
              sv_fe_q     <= 1'b0;
              sv_end_q    <= `LBCU_RST24;
              sv_cnt_q    <= `LBCU_RST24;
              brk_q       <= (op == `LBCU_OP_BRK);
              PC_LOAD     <= 1'b1;
              PC_TARGET   <= lp_next; // RULE_18
            end else if (LOOP_ACTIVE && !lp_fe_q &&
                         (op == `LBCU_OP_STEP)) begin
              lp_cnt_q <= lp_cnt_q - 24'h000001;
            end
          end
          default: brk_q <= brk_q;
        endcase
      end
    end
  end

endmodule // lbcu_top
`default_nettype wire

// ### hw/lbcu_defines.vh
`ifndef LBCU_DEFINES_VH
`define LBCU_DEFINES_VH
// register byte offsets, haddr[7:0]
`define LBCU_A_ACC_LO 8'h00
`define LBCU_A_ACC_HI 8'h04
`define LBCU_A_OPND   8'h08
`define LBCU_A_CTRL   8'h0C
`define LBCU_A_PC     8'h10
`define LBCU_A_FLAGS  8'h14
`define LBCU_A_CMD    8'h18
`define LBCU_A_RES_LO 8'h1C
`define LBCU_A_RES_HI 8'h20
`define LBCU_A_LSTAT  8'h24
`define LBCU_A_LEND   8'h28
`define LBCU_A_LCNT   8'h2C
// command word fields
`define LBCU_CMD_OP   3:0
`define LBCU_CMD_CC   7:4
`define LBCU_CMD_SRC  9:8
`define LBCU_CMD_M16  10
// operation codes
`define LBCU_OP_AND   4'h0
`define LBCU_OP_EOR   4'h1
`define LBCU_OP_OR    4'h2
`define LBCU_OP_COUNT_LEADING_BITS 4'h3
`define LBCU_OP_EXT   4'h4
`define LBCU_OP_EXTU  4'h5
`define LBCU_OP_INS   4'h6
`define LBCU_OP_LOGICAL_LEFT_SHIFT       4'h7
`define LBCU_OP_LOGICAL_RIGHT_SHIFT      4'h8
`define LBCU_OP_PC_RELATIVE_LOOP_START   4'h9
`define LBCU_OP_ENDLESS_RELATIVE_LOOP    4'hA
`define LBCU_OP_BRK   4'hB
`define LBCU_OP_PC_RELATIVE_ADDRESS_LOAD 4'hC
`define LBCU_OP_STEP  4'hD
// operand source select
`define LBCU_SRC_REG   2'h0
`define LBCU_SRC_SHORT 2'h1
`define LBCU_SRC_LONG  2'h2
// control word field positions
`define LBCU_WID      17:12
`define LBCU_OFF      5:0
`define LBCU_WID16    21:16
`define LBCU_OFF16    13:8
// flag bit positions
`define LBCU_F_C 0
`define LBCU_F_V 1
`define LBCU_F_Z 2
`define LBCU_F_N 3
`define LBCU_F_U 4
`define LBCU_F_E 5
`define LBCU_F_L 6
// reset values and the leading-bit count base
`define LBCU_RST24 24'h000000
`define LBCU_RST56 56'h00000000000000
`define LBCU_LEAD_BASE 24'h000009
`endif

// ### verification/lbcu_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbcu_seq (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pc_load,
  input  wire logic [23:0] pc_target,
  output logic      [23:0] jump_pc,
  output logic      [7:0]  jumps
);
  // sequencer side: redirects fetch on each pulse and counts the redirects
  always_ff @(posedge clk) begin
    if (rst) begin
      jump_pc <= 24'h000000;
      jumps   <= 8'h00;
    end else if (pc_load) begin
      jump_pc <= pc_target;
      jumps   <= jumps + 8'h01;
    end
  end
endmodule // lbcu_seq
`default_nettype wire

// ### verification/lbcu_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lbcu_chk (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        LOOP_ACTIVE,
  input wire logic        PC_LOAD,
  input wire logic [23:0] PC_TARGET
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire tk = HSEL & HTRANS[1] & HREADY;
  wire wt = tk & HWRITE;
  property p_okay; !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd; tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_wr; wt |=> HREADYOUT; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_pulse; PC_LOAD |=> !PC_LOAD; endproperty
  a_pulse: assert property (p_pulse) else $error("jump pulse long");
  property p_tgt; $changed(PC_TARGET) |-> PC_LOAD; endproperty
  a_tgt: assert property (p_tgt) else $error("target moved alone");
  property p_ld; PC_LOAD |-> $past(wt, 2); endproperty
  a_ld: assert property (p_ld) else $error("jump without command");
  property p_loop; $changed(LOOP_ACTIVE) |-> $past(wt, 2); endproperty
  a_loop: assert property (p_loop) else $error("loop state moved");
  property p_hrd; $changed(HRDATA) |-> !$past(HREADYOUT); endproperty
  a_hrd: assert property (p_hrd) else $error("read data moved");
endmodule // lbcu_chk
bind lbcu_top lbcu_chk u_lbcu_chk (.REF_CLK, .RST, .HSEL, .HTRANS, .HWRITE,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .LOOP_ACTIVE, .PC_LOAD, .PC_TARGET);
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_d;
  wire  [31:0] hrdata;
  wire         hrdy, hresp, lact, pcl;
  wire  [23:0] pct, jpc;
  wire  [7:0]  jumps;
  int          failures = 0, num_checks = 0, cyc = 0;
  logic [55:0] acc, r;
  logic [23:0] op, ct, pc;
  logic [10:0] cm;
  logic [3:0]  ol [6] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8, 4'hC};
  logic [55:0] la [4] = '{56'h00FFFFFFFFFFFF, 56'hF0000000000000,
                          56'h00000000000001, 56'hFFFFFFFFFFFFFF};
  always #50 clk = ~clk;
  lbcu_top u_lbcu_top (.REF_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
    .LOOP_ACTIVE(lact), .PC_LOAD(pcl), .PC_TARGET(pct));
  lbcu_seq u_lbcu_seq (.clk(clk), .rst(rst), .pc_load(pcl), .pc_target(pct),
    .jump_pc(jpc), .jumps(jumps));
  task chk(input logic [55:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd_d = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task run(input logic [10:0] c);
    wr(8'h18, {21'h0, c});
    rd(8'h1C);
    r[31:0] = rd_d;
    rd(8'h20);
    r[55:32] = rd_d[23:0];
  endtask
  task setup(input logic [55:0] a, input logic [23:0] o, c);
    acc = a; op = o; ct = c;
    wr(8'h00, a[31:0]);
    wr(8'h04, {8'h0, a[55:32]});
    wr(8'h08, {8'h0, o});
    wr(8'h0C, {8'h0, c});
  endtask
  function automatic logic [55:0] ex(input logic [10:0] c);
    logic [23:0] v, o;
    logic [5:0]  w, f;
    logic [55:0] m;
    int n;
    v = acc[47:24];
    o = (c[9:8] == 2'h1) ? {18'h0, op[5:0]} : op;
    w = c[10] ? ct[21:16] : ct[17:12];
    f = c[10] ? ct[13:8] : ct[5:0];
    m = (56'h1 << w) - 56'h1;
    n = (c[9:8] == 2'h0) ? 1 : (c[9:8] == 2'h1) ? op[4:0] : ct[4:0];
    case (c[3:0])
      4'h0: v = v & o;
      4'h1: v = v ^ o;
      4'h2: v = v | o;
      4'h3: begin
        n = 0;
        while (n < 56 && acc[55-n] == acc[55]) n++;
        v = 24'h9 - n[23:0];
      end
      4'h4, 4'h5: begin
        ex = (acc >> f) & m;
        if (!c[0] && ex[w-6'h1]) ex = ex | ~m;
        return ex;
      end
      4'h6: return (acc & ~(m << f)) | (({32'h0, op} & m) << f);
      4'h7: v = (n > 23) ? 24'h0 : v << n;
      4'h8: v = (n > 23) ? 24'h0 : v >> n;
      4'hC: return {32'h0, pc + op};
      default: ;
    endcase
    return {acc[55:48], v, acc[23:0]};
  endfunction
  function automatic logic cnd(input logic [3:0] c, input logic [6:0] f);
    logic nv, zn, ue;
    logic [15:0] t;
    nv = f[3] ^ f[1];
    zn = f[2] | nv;
    ue = f[2] | (f[4] & f[5]);
    t = {!ue, !f[3], ue, !f[2], f[3], nv, f[6], zn,
         !f[6], !zn, !nv, f[5], f[2], !f[5], f[0], !f[0]};
    return t[c];
  endfunction
  task conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    setup(56'h123456C39ABCDE, 24'hF0F025, 24'h000017);
    pc = 24'hFFFFF0;
    wr(8'h10, {8'h0, pc});
    for (int i = 0; i < 6; i++) for (int s = 0; s < 3; s++) begin
      cm = {1'b0, s[1:0], 4'h0, ol[i]};
      run(cm);
      chk(r, ex(cm));
    end
    foreach (la[i]) begin
      setup(la[i], op, ct);
      run(11'h003);
      chk(r, ex(11'h003));
    end
    $display("test logic shift count done");
    // control word holds distinct fields for both modes
    setup(56'h00000000A00700, 24'hFFFFF5, 24'h104814);
    for (int m = 0; m < 2; m++) for (int o = 4; o < 7; o++) begin
      cm = {m[0], 6'h0, o[3:0]};
      run(cm);
      chk(r, ex(cm));
    end
    $display("test bitfield done");
    // exit with no loop active only shows the condition
    for (int f = 0; f < 128; f++) begin
      wr(8'h14, f);
      for (int c = 0; c < 16; c++) begin
        wr(8'h18, {24'h0, c[3:0], 4'hB});
        rd(8'h24);
        chk(rd_d[3], cnd(c[3:0], f[6:0]));
      end
    end
    $display("test conditions done");
    wr(8'h10, 32'h100);
    wr(8'h08, 32'h10);
    wr(8'h0C, 32'h2);
    wr(8'h18, 32'h9);
    rd(8'h28);
    chk(rd_d, 32'h110);
    rd(8'h2C);
    chk(rd_d, 32'h2);
    chk(lact, 1'b1);
    wr(8'h18, 32'hD);
    wr(8'h18, 32'hD);
    rd(8'h24);
    chk({lact, rd_d[0], jpc, jumps}, {2'b00, 24'h111, 8'h01});
    wr(8'h18, 32'h9);
    wr(8'h10, 32'h200);
    wr(8'h08, 32'h8);
    wr(8'h18, 32'hA);
    rd(8'h24);
    chk(rd_d[2:0], 3'h7);
    // every flag is still set: not-equal is false, equal is true
    wr(8'h18, 32'hCB);
    wr(8'h18, 32'h3B);
    rd(8'h28);
    chk(rd_d, 32'h110);
    chk({lact, jpc, jumps}, {1'b1, 24'h209, 8'h02});
    wr(8'h18, 32'h3B);
    rd(8'h24);
    chk({lact, rd_d[4], rd_d[0], jpc, jumps},
        {3'b010, 24'h111, 8'h03});
    $display("test loops done");
    wr(8'h30, 32'h1234);
    rd(8'h30);
    chk(rd_d, 32'h0);
    rd(8'h10);
    chk(rd_d, 32'h200);
    chk(hresp, 1'b0);
    $display("test map done");
    conclude;
  end
endmodule // tb
`default_nettype wire
